// *** rcws_pkg.sv ***
// Functional notes
// - first output word of the slot is the request control word
// - control word low byte is the command sent as request code
// - nonzero bits 8 to 13 of the high byte override the derived response setting; only nonzero bits 8 to 12 override length
// - length from five low bits of high byte; zero means table default
// - lengths above six bytes send only the first six data bytes
// - high byte holds send trigger, repetitive and response-required bits
// - send once on cleared-to-set trigger edge; steady level sends nothing more
// - broadcast channel ignores trigger, repetitive and response-required bits
// - repetitive bit sends at every scan while idle, ignoring trigger and its history
// - with response required, wait for the unit's answer after sending
// - no answer to a required request marks the unit failed and logs it out
// - data byte 0 low byte of first data word, byte 1 high, onward
// - message is command byte followed by data block bytes
// - status poll slot has four input and four output words
// - per-command default table of data length and response expectation
// - message-sent ack set after send, held while trigger set, cleared with it
`default_nettype none
package rcws_pkg;
	localparam int CMD_LSB = 0;
	localparam int LEN_LSB = 8;
	localparam int LEN_W = 5;
	localparam int RSPREQ_BIT = 13;
	localparam int REPEAT_BIT = 14;
	localparam int SEND_BIT = 15;
	localparam int MAX_DATA_BYTES = 6;
	localparam int SLOT_WORDS = 4;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam int RSP_TIMEOUT_NS = 100000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RSP_TIMEOUT_CYC = (RSP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {RCWS_IDLE, RCWS_SEND, RCWS_WAIT} rcws_state_t;
endpackage : rcws_pkg
`default_nettype wire

// *** rcws_msg_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface rcws_msg_if;
	logic [7:0] cmd;
	logic [2:0] len;
	logic rsp;
	modport table_side (input cmd, output len, output rsp);
	modport user (output cmd, input len, input rsp);
endinterface : rcws_msg_if
`default_nettype wire

// *** rcws_default_table.sv ***
`timescale 1ns/10ps
`default_nettype none
// ***************
// default request parameters per command
// ***************
module rcws_default_table (
	rcws_msg_if.table_side tbl
);
	always_comb begin
		tbl.len = 3'h0;
		tbl.rsp = 1'b0;
		case (tbl.cmd)
			8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hFF: begin
				tbl.rsp = 1'b1;
			end
			8'h30, 8'h31, 8'h32, 8'h33, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
			8'h46, 8'h47, 8'h49, 8'h4A, 8'h4C, 8'h4D, 8'h4E, 8'h4F: begin
				tbl.len = 3'h1;
			end
			8'h4B, 8'hA1: begin
				tbl.len = 3'h2;
			end
			8'h51: begin
				tbl.len = 3'h3;
			end
			default: begin
				tbl.len = 3'h0;
			end
		endcase
	end
endmodule : rcws_default_table
`default_nettype wire

// *** rcws_sender.sv ***
`timescale 1ns/10ps
`default_nettype none
module rcws_sender #(
	parameter int RSP_TIMEOUT = rcws_pkg::RSP_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic NRST_I,
	// slot output words and scan
	input wire logic SCAN_I,
	input wire logic BROADCAST_I,
	input wire logic [15:0] OUTPUT_WORD_POINT_I [rcws_pkg::SLOT_WORDS],
	// field link
	output logic MSG_VALID_O,
	output logic [7:0] MSG_CMD_O,
	output logic [2:0] MSG_LEN_O,
	output logic [47:0] MSG_DATA_O,
	input wire logic RSP_VALID_I,
	// status
	output logic MSG_SENT_O,
	output logic WAIT_RSP_O,
	output logic UNIT_FAILED_O
);
	// ***************
	// request decode
	// ***************
	logic [15:0] ctrl;
	logic [7:0] cmd;
	logic [4:0] ovr_len;
	logic [2:0] eff_len;
	logic eff_rsp;
	logic override;
	logic trig_edge;
	logic do_send;
	logic [47:0] data_bytes;
	rcws_msg_if tif ();
	rcws_default_table i_rcws_default_table (.tbl(tif));
	assign ctrl = OUTPUT_WORD_POINT_I[0];
	assign cmd = ctrl[rcws_pkg::CMD_LSB +: 8];
	assign tif.cmd = cmd;
	assign ovr_len = ctrl[rcws_pkg::LEN_LSB +: rcws_pkg::LEN_W];
	// send and repeat bits alone keep the table defaults; under override a zero length field still takes the table length
	assign override = (ctrl[rcws_pkg::RSPREQ_BIT:rcws_pkg::LEN_LSB] != 6'h00);
	always_comb begin
		// zero length field falls back to the table even under override
		if (ovr_len == 5'h00) begin
			eff_len = tif.len;
		end else if (ovr_len > 5'(rcws_pkg::MAX_DATA_BYTES)) begin
			eff_len = 3'(rcws_pkg::MAX_DATA_BYTES);
		end else begin
			eff_len = ovr_len[2:0];
		end
		eff_rsp = override ? ctrl[rcws_pkg::RSPREQ_BIT] : tif.rsp;
		if (BROADCAST_I) begin
			eff_rsp = 1'b0;
		end
	end
	// byte 0 low, byte 1 high, per word
	assign data_bytes = {OUTPUT_WORD_POINT_I[3], OUTPUT_WORD_POINT_I[2],
		OUTPUT_WORD_POINT_I[1]};

	// ***************
	// send control
	// ***************
	rcws_pkg::rcws_state_t state_ff, nxt_state;
	logic prev_trig_ff, nxt_prev_trig;
	logic sent_ff, nxt_sent;
	logic failed_ff, nxt_failed;
	logic valid_ff, nxt_valid;
	logic [7:0] cmd_ff, nxt_cmd;
	logic [2:0] len_ff, nxt_len;
	logic [47:0] data_ff, nxt_data;
	logic [31:0] tmo_ff, nxt_tmo;
	logic rsp_pend_ff, nxt_rsp_pend;
	logic wait_ff, nxt_wait;
	assign trig_edge = ctrl[rcws_pkg::SEND_BIT] & ~prev_trig_ff;
	assign do_send = SCAN_I & ~BROADCAST_I & ~failed_ff & (state_ff == rcws_pkg::RCWS_IDLE) &
		(ctrl[rcws_pkg::REPEAT_BIT] | trig_edge);
	always_comb begin
		nxt_state = state_ff;
		nxt_prev_trig = prev_trig_ff;
		nxt_sent = sent_ff;
		nxt_failed = failed_ff;
		nxt_valid = 1'b0;
		nxt_cmd = cmd_ff;
		nxt_len = len_ff;
		nxt_data = data_ff;
		nxt_tmo = tmo_ff;
		nxt_rsp_pend = rsp_pend_ff;
		if (SCAN_I) begin
			nxt_prev_trig = ctrl[rcws_pkg::SEND_BIT];
		end
		if (!ctrl[rcws_pkg::SEND_BIT]) begin
			nxt_sent = 1'b0;
		end
		case (state_ff)
			rcws_pkg::RCWS_IDLE: begin
				if (do_send) begin
					nxt_cmd = cmd;
					nxt_len = eff_len;
					nxt_data = data_bytes;
					nxt_rsp_pend = eff_rsp;
					nxt_state = rcws_pkg::RCWS_SEND;
				end
			end
			rcws_pkg::RCWS_SEND: begin
				nxt_valid = 1'b1;
				nxt_sent = ctrl[rcws_pkg::SEND_BIT] | ctrl[rcws_pkg::REPEAT_BIT];
				nxt_tmo = 32'(RSP_TIMEOUT);
				nxt_state = rsp_pend_ff ? rcws_pkg::RCWS_WAIT : rcws_pkg::RCWS_IDLE;
			end
			rcws_pkg::RCWS_WAIT: begin
				if (RSP_VALID_I) begin
					nxt_state = rcws_pkg::RCWS_IDLE;
				end else if (tmo_ff <= 32'h1) begin
					nxt_failed = 1'b1;
					nxt_state = rcws_pkg::RCWS_IDLE;
				end else begin
					nxt_tmo = tmo_ff - 32'h1;
				end
			end
			default: begin
				nxt_state = rcws_pkg::RCWS_IDLE;
			end
		endcase
		nxt_wait = (nxt_state == rcws_pkg::RCWS_WAIT);
	end
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_ff <= rcws_pkg::RCWS_IDLE;
			prev_trig_ff <= 1'b0;
			sent_ff <= 1'b0;
			failed_ff <= 1'b0;
			valid_ff <= 1'b0;
			cmd_ff <= 8'h00;
			len_ff <= 3'h0;
			data_ff <= 48'h000000000000;
			tmo_ff <= 32'h0;
			rsp_pend_ff <= 1'b0;
			wait_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			prev_trig_ff <= nxt_prev_trig;
			sent_ff <= nxt_sent;
			failed_ff <= nxt_failed;
			valid_ff <= nxt_valid;
			cmd_ff <= nxt_cmd;
			len_ff <= nxt_len;
			data_ff <= nxt_data;
			tmo_ff <= nxt_tmo;
			rsp_pend_ff <= nxt_rsp_pend;
			wait_ff <= nxt_wait;
		end
	end
	assign MSG_VALID_O = valid_ff;
	assign MSG_CMD_O = cmd_ff;
	assign MSG_LEN_O = len_ff;
	assign MSG_DATA_O = data_ff;
	assign MSG_SENT_O = sent_ff;
	assign WAIT_RSP_O = wait_ff;
	assign UNIT_FAILED_O = failed_ff;

	// ***************
	// checks
	// ***************
	sequence s_send_req;
		do_send;
	endsequence
	sequence s_msg_out;
		##1 valid_ff;
	endsequence
	a_edge_sends: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		s_send_req |-> ##1 s_msg_out) else $error("send request did not emit message");
	a_level_no_resend: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(SCAN_I && prev_trig_ff && !ctrl[rcws_pkg::REPEAT_BIT] && state_ff == rcws_pkg::RCWS_IDLE)
		|=> !(state_ff == rcws_pkg::RCWS_SEND)) else $error("steady trigger resent");
	a_bcast_no_send: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		BROADCAST_I |-> !do_send) else $error("broadcast send occurred");
	a_len_capped: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		valid_ff |-> len_ff <= 3'(rcws_pkg::MAX_DATA_BYTES)) else $error("length over six");
	a_repeat_sends: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(SCAN_I && ctrl[rcws_pkg::REPEAT_BIT] && !BROADCAST_I && !failed_ff
		&& state_ff == rcws_pkg::RCWS_IDLE) |-> ##2 valid_ff) else $error("repeat send missed");
	a_wait_after_rsp: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(valid_ff && $past(rsp_pend_ff)) |-> state_ff == rcws_pkg::RCWS_WAIT)
		else $error("no wait for response");
	a_fail_timeout: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(state_ff == rcws_pkg::RCWS_WAIT && tmo_ff == 32'h1 && !RSP_VALID_I) |=> failed_ff)
		else $error("silent unit not failed");
	a_ack_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(!ctrl[rcws_pkg::SEND_BIT] && state_ff != rcws_pkg::RCWS_SEND) |=> !sent_ff)
		else $error("ack not cleared");
	a_cmd_copied: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		do_send |=> cmd_ff == $past(cmd)) else $error("command not sent");
	a_override_rsp: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(do_send && ctrl[rcws_pkg::RSPREQ_BIT:rcws_pkg::LEN_LSB] != 6'h00)
		|=> rsp_pend_ff == $past(ctrl[rcws_pkg::RSPREQ_BIT]))
		else $error("response override ignored");
	a_len_override: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(do_send && ovr_len != 5'h00 && ovr_len <= 5'(rcws_pkg::MAX_DATA_BYTES))
		|=> len_ff == $past(ovr_len[2:0])) else $error("length override ignored");
	a_table_len: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(do_send && ctrl[rcws_pkg::RSPREQ_BIT:rcws_pkg::LEN_LSB] == 6'h00 && cmd == 8'h51)
		|=> (len_ff == 3'h3 && !rsp_pend_ff)) else $error("table length wrong");
	a_table_rsp: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(do_send && ctrl[rcws_pkg::RSPREQ_BIT:rcws_pkg::LEN_LSB] == 6'h00 && cmd == 8'hFF)
		|=> (rsp_pend_ff && len_ff == 3'h0)) else $error("table response wrong");
	a_bcast_no_rsp: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		BROADCAST_I |-> !eff_rsp) else $error("broadcast response required");
	a_fail_sticky: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		failed_ff |=> failed_ff) else $error("failed unit logged back in");
	a_fail_no_send: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		failed_ff |-> !do_send) else $error("failed unit still addressed");
	a_data_order: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		do_send |=> (data_ff[7:0] == $past(OUTPUT_WORD_POINT_I[1][7:0])
		&& data_ff[47:40] == $past(OUTPUT_WORD_POINT_I[3][15:8])))
		else $error("data byte order wrong");
	a_rsp_ends_wait: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(wait_ff && RSP_VALID_I) |=> !wait_ff) else $error("wait kept after answer");
	a_trig_stored: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		SCAN_I |=> prev_trig_ff == $past(ctrl[rcws_pkg::SEND_BIT]))
		else $error("trigger history not stored");
	a_sent_held: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(sent_ff && ctrl[rcws_pkg::SEND_BIT]) |=> sent_ff) else $error("ack dropped early");
endmodule : rcws_sender
`default_nettype wire

// *** rcws_unit_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ***************
// field unit: answers after a delay, or stays silent
// ***************
module rcws_unit_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// link from the sender
	input wire logic msg_valid_i,
	input wire logic wait_i,
	// behaviour
	input wire logic silent_i,
	input wire logic [2:0] dly_i,
	output logic rsp_valid_o
);
	int cnt;
	// a silent unit never answers, so the sender must log it out
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= 0;
			rsp_valid_o <= 1'b0;
		end else begin
			rsp_valid_o <= 1'b0;
			if (msg_valid_i && wait_i && !silent_i) begin
				cnt <= int'(dly_i) + 1;
			end else if (cnt == 1) begin
				cnt <= 0;
				rsp_valid_o <= 1'b1;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : rcws_unit_model
`default_nettype wire

// *** rcws_sender_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module rcws_sender_test;
	logic clk = 0, nrst = 0, scan = 0, bc = 0, silent = 0, rsp, vld, sent, wt, fail;
	logic [15:0] w [4];
	logic [15:0] c;
	logic [7:0] cmd;
	logic [2:0] len;
	logic [2:0] dly = 0;
	logic [47:0] dat;
	int err_total = 0, samples_checked = 0, seed = 74;
	logic [7:0] tbl [8] = '{8'h01, 8'h30, 8'h4B, 8'h51, 8'hA1, 8'hFF, 8'h06, 8'h4F};
	always #5 clk = ~clk;
	rcws_sender #(.RSP_TIMEOUT(16)) i_rcws_sender (.CLK_I(clk), .NRST_I(nrst), .SCAN_I(scan),
		.BROADCAST_I(bc), .OUTPUT_WORD_POINT_I(w), .MSG_VALID_O(vld), .MSG_CMD_O(cmd),
		.MSG_LEN_O(len), .MSG_DATA_O(dat), .RSP_VALID_I(rsp), .MSG_SENT_O(sent),
		.WAIT_RSP_O(wt), .UNIT_FAILED_O(fail));
	rcws_unit_model i_rcws_unit_model (.clk_i(clk), .nrst_i(nrst), .msg_valid_i(vld),
		.wait_i(wt), .silent_i(silent), .dly_i(dly), .rsp_valid_o(rsp));
	// ***************
	// checking
	// ***************
	task automatic end_of_test;
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// default byte counts; only listed commands are used unoverridden
	function automatic int dlen(input logic [7:0] k);
		case (k)
			8'h01, 8'h06, 8'hFF: return 0;
			8'h4B, 8'hA1: return 2;
			8'h51: return 3;
			default: return 1;
		endcase
	endfunction : dlen
	// response expected: override field wins, else the table
	function automatic logic drsp(input logic [15:0] cw);
		if (cw[13:8] != 6'h00) return cw[13];
		case (cw[7:0])
			8'h01, 8'h06, 8'hFF: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : drsp
	task automatic go(input logic [15:0] cw, input logic exp);
		int n, k;
		logic [47:0] m;
		@(negedge clk);
		w[0] = cw;
		for (k = 1; k < 4; k++) w[k] = 16'($random(seed));
		scan = 1;
		@(negedge clk);
		scan = 0;
		for (k = 0; k < 4 && vld !== 1'b1; k++) @(negedge clk);
		chk(vld, exp);
		if (vld === 1'b1) begin
			n = cw[12:8] == 0 ? dlen(cw[7:0]) : (cw[12:8] > 6 ? 6 : int'(cw[12:8]));
			m = (48'h1 << (8 * n)) - 48'h1;
			chk(cmd, cw[7:0]);
			chk(len, n);
			chk(dat & m, {w[3], w[2], w[1]} & m);
			chk(wt, drsp(cw));
			chk(sent, cw[15] | cw[14]);
		end
		for (k = 0; k < 40 && wt !== 1'b0; k++) @(negedge clk);
		if (wt !== 1'b0) begin
			chk(wt, 1'b0);
			end_of_test;
		end
		@(negedge clk);
		if (!cw[15]) chk(sent, 0);
	endtask : go
	// ***************
	// scenarios
	// ***************
	initial begin
		for (int k = 0; k < 4; k++) w[k] = 16'h0000;
		repeat (6) @(negedge clk);
		nrst = 1;
		repeat (8) begin
			c = {3'b000, 5'($random(seed)), tbl[$unsigned($random(seed)) % 8]};
			c[13] = 1'($random(seed));
			dly = 3'($random(seed));
			go(c, 0);
			go(c | 16'h8000, 1);
			go(c | 16'h8000, 0);
		end
		go(c, 0);
		go(c | 16'h4000, 1);
		go(c | 16'hC000, 1);
		bc = 1;
		go(16'h0001, 0);
		go(16'hE001, 0);
		bc = 0;
		go(16'h0001, 0);
		go(16'h8051, 1);
		go(16'h0051, 0);
		go(16'h80FF, 1);
		go(16'h00FF, 0);
		silent = 1;
		go(16'hA0FF, 1);
		chk(fail, 1);
		go(16'h0001, 0);
		go(16'h8001, 0);
		end_of_test;
	end
endmodule : rcws_sender_test
`default_nettype wire
